// ===== inc/aux_consts.svh
`ifndef AUX_CONSTS_SVH
`define AUX_CONSTS_SVH

// ****************************************************************
// Parameter indices within the auxiliary group
// ****************************************************************
`define IDX_SW_RESET     8'h00
`define IDX_FAULT_RESET  8'h01
`define IDX_ESTOP        8'h05
`define IDX_ADJ_SEL      8'h0A
`define IDX_IO_MODE      8'h11
`define IDX_DI_FORCE     8'h12
`define IDX_DO_FORCE     8'h13
`define IDX_ENC_CMD      8'h14
`define IDX_GRAV         8'h18

// ****************************************************************
// Setting ranges
// ****************************************************************
`define MAX_ONE_BIT      16'h0001
`define MAX_ADJ_SEL      16'h0002
`define MAX_IO_MODE      16'h0003
`define MAX_DI_FORCE     16'h01FF
`define MAX_DO_FORCE     16'h001F
`define MAX_ENC_CMD      16'h0002

// ****************************************************************
// Defaults and encodings
// ****************************************************************
`define RST_DI_FORCE     9'h1FF
`define ADJ_AIN_ONE      2'h1
`define ADJ_AIN_TWO      2'h2
`define ENC_CLR_FAULTS   2'h1
`define ENC_CLR_TURNS    2'h2
`define IO_BIT_DI        0
`define IO_BIT_DO        1
`define ADJ_LOG2_SAMPLES 8

`endif

// ===== inc/aux_pkg.sv
package aux_pkg;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic        from_comm;
        logic [7:0]  idx;
        logic [15:0] wdata;
    } param_req_t;

    typedef struct packed {
        logic        ack;
        logic        err;
        logic [15:0] rdata;
    } param_rsp_t;

    typedef enum logic [1:0] {
        ADJ_IDLE,
        ADJ_SUM,
        ADJ_OUT
    } adj_state_t;

endpackage : aux_pkg

// ===== src/io_force_unit.sv
`timescale 1ns/1ns
`include "aux_consts.svh"

module io_force_unit (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       ce_in,
    input  wire logic [8:0] di_pin_in,
    input  wire logic       di_force_in,
    input  wire logic [8:0] di_levels_in,
    input  wire logic       do_force_in,
    input  wire logic [4:0] do_states_in,
    input  wire logic [4:0] do_func_in,
    input  wire logic [4:0] do_polarity_in,
    output logic      [8:0] di_level_out,
    output logic      [4:0] do_pin_out
);

    // ****************************************************************
    // Pin synchroniser, change taken once stages two and three agree
    // ****************************************************************
    logic [8:0] s1_reg;
    logic [8:0] s2_reg;
    logic [8:0] s3_reg;
    logic [8:0] filt_reg;
    wire  [8:0] agree      = s2_reg ~^ s3_reg;
    wire  [8:0] filt_next  = (agree & s2_reg) | (~agree & filt_reg);
    wire  [8:0] di_next    = di_force_in ? di_levels_in : filt_next;
    wire  [4:0] do_valid   = do_force_in ? do_states_in : do_func_in;
    // Polarity 0 drives the pin low while the function is valid
    wire  [4:0] do_next    = ~(do_valid ^ do_polarity_in);

    always_ff @(posedge clk_in) begin
        if (ce_in) begin
            if (rst_in) begin
                s1_reg       <= 9'h000;
                s2_reg       <= 9'h000;
                s3_reg       <= 9'h000;
                filt_reg     <= 9'h000;
                di_level_out <= 9'h000;
                do_pin_out   <= 5'h00;
            end else begin
                s1_reg       <= di_pin_in;
                s2_reg       <= s1_reg;
                s3_reg       <= s2_reg;
                filt_reg     <= filt_next;
                di_level_out <= di_next;
                do_pin_out   <= do_next;
            end
        end
    end

endmodule : io_force_unit

// ===== src/drift_adjust.sv
`timescale 1ns/1ns
`include "aux_consts.svh"

module drift_adjust (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        ce_in,
    input  wire logic        start_in,
    input  wire logic [1:0]  sel_in,
    input  wire logic [15:0] ain1_in,
    input  wire logic [15:0] ain2_in,
    input  wire logic        sample_valid_in,
    output logic             busy_out,
    output logic             done_out,
    output logic      [1:0]  done_sel_out,
    output logic      [15:0] offset_out
);

    localparam int ACC_W = 16 + `ADJ_LOG2_SAMPLES;

    aux_pkg::adj_state_t state_reg;
    aux_pkg::adj_state_t state_next;
    logic signed [ACC_W-1:0]            acc_reg;
    logic [`ADJ_LOG2_SAMPLES-1:0]       cnt_reg;
    logic [1:0]                         sel_reg;

    wire  [15:0]             sample  = (sel_reg == `ADJ_AIN_TWO) ? ain2_in : ain1_in;
    wire  signed [ACC_W-1:0] sext    = ACC_W'(signed'(sample));
    wire                     take    = (state_reg == aux_pkg::ADJ_SUM) & sample_valid_in;
    wire                     last    = take & (&cnt_reg);
    // Mean is the drift; the correction cancels it
    wire  signed [ACC_W-1:0] mean    = (acc_reg + sext) >>> `ADJ_LOG2_SAMPLES;
    wire  [15:0]             corr    = 16'(-mean);

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            aux_pkg::ADJ_IDLE: if (start_in) state_next = aux_pkg::ADJ_SUM;
            aux_pkg::ADJ_SUM:  if (last) state_next = aux_pkg::ADJ_OUT;
            aux_pkg::ADJ_OUT:  state_next = aux_pkg::ADJ_IDLE;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (ce_in) begin
            if (rst_in) begin
                state_reg    <= aux_pkg::ADJ_IDLE;
                acc_reg      <= '0;
                cnt_reg      <= '0;
                sel_reg      <= 2'h0;
                busy_out     <= 1'b0;
                done_out     <= 1'b0;
                done_sel_out <= 2'h0;
                offset_out   <= 16'h0000;
            end else begin
                state_reg <= state_next;
                busy_out  <= (state_next != aux_pkg::ADJ_IDLE);
                done_out  <= last;
                if (start_in && state_reg == aux_pkg::ADJ_IDLE) begin
                    sel_reg <= sel_in;
                    acc_reg <= '0;
                    cnt_reg <= '0;
                end else if (take) begin
                    acc_reg <= acc_reg + sext;
                    cnt_reg <= cnt_reg + 1'b1;
                end
                if (last) begin
                    offset_out   <= corr;
                    done_sel_out <= sel_reg;
                end
            end
        end
    end

endmodule : drift_adjust

// ===== src/aux_function_control.sv
`timescale 1ns/1ns
`include "aux_consts.svh"

// Overview of operation
// - A granted software reset pulses a program reset like power-on.
// - Software reset waits for servo off, no hard fault, no memory work.
// - Software reset requests are dropped while reset inhibit is set.
// - Fault reset clears class one and two faults once stopped, enters ready.
// - Fault reset clears class three warnings at once, any servo state.
// - Non-resettable faults untouched; only indication cleared by fault reset.
// - Emergency stop setting drives a stop using the chosen stop mode.
// - Analog selector: 0 off, 1 analog input one, 2 analog input two.
// - Adjustment measures zero drift and writes correction to the offset.
// - Forcing mode: 0 none, 1 inputs, 2 outputs, 3 both.
// - Forced input word bit n sets input function n+1; default all ones.
// - Forced output word bit n validates output function n+1; default zero.
// - Output pin level combines validity with polarity; 0 means low valid.
// - Encoder command: 0 nothing, 1 clear faults, 2 faults and turns.
// - Gravity trigger 1 starts tuning; success stores result, returns to 0.
// - Serial-link writes to this group are never saved to nonvolatile memory.

module aux_function_control (
    input  wire logic                CLK_SYS_IN,
    input  wire logic                SRST_IN,
    input  wire logic                CE_IN,
    input  wire aux_pkg::param_req_t PARAM_REQ_IN,
    input  wire logic                SERVO_ON_IN,
    input  wire logic                RUNNING_IN,
    input  wire logic                NONRESET_FAULT_IN,
    input  wire logic                NVM_BUSY_IN,
    input  wire logic                RESET_INHIBIT_IN,
    input  wire logic [1:0]          STOP_MODE_IN,
    input  wire logic [15:0]         AIN1_IN,
    input  wire logic [15:0]         AIN2_IN,
    input  wire logic                AIN_VALID_IN,
    input  wire logic [8:0]          DI_PIN_IN,
    input  wire logic [4:0]          DO_FUNC_IN,
    input  wire logic [4:0]          DO_POLARITY_IN,
    input  wire logic                GRAV_DONE_IN,
    input  wire logic                GRAV_OK_IN,
    input  wire logic [15:0]         GRAV_RESULT_IN,
    output aux_pkg::param_rsp_t      PARAM_RSP_OUT,
    output logic                     PERSIST_REQ_OUT,
    output logic                     SOFT_RESET_OUT,
    output logic                     WARN_CLEAR_OUT,
    output logic                     FAULT_CLEAR_OUT,
    output logic                     ESTOP_OUT,
    output logic [1:0]               ESTOP_MODE_OUT,
    output logic                     ANA_OFFSET_WR_OUT,
    output logic [1:0]               ANA_OFFSET_SEL_OUT,
    output logic [15:0]              ANA_OFFSET_OUT,
    output logic [8:0]               DI_LEVEL_OUT,
    output logic [4:0]               DO_PIN_OUT,
    output logic                     ENC_FAULT_CLR_OUT,
    output logic                     ENC_TURNS_CLR_OUT,
    output logic                     GRAV_START_OUT,
    output logic                     GRAV_RESULT_WR_OUT,
    output logic [15:0]              GRAV_RESULT_OUT
);

    // ****************************************************************
    // Index decode and range checks
    // ****************************************************************
    function automatic logic idx_known(input logic [7:0] idx);
        idx_known = (idx == `IDX_SW_RESET) || (idx == `IDX_FAULT_RESET) ||
                    (idx == `IDX_ESTOP)    || (idx == `IDX_ADJ_SEL)     ||
                    (idx == `IDX_IO_MODE)  || (idx == `IDX_DI_FORCE)    ||
                    (idx == `IDX_DO_FORCE) || (idx == `IDX_ENC_CMD)     ||
                    (idx == `IDX_GRAV);
    endfunction : idx_known

    function automatic logic [15:0] idx_max(input logic [7:0] idx);
        idx_max = `MAX_ONE_BIT;
        if (idx == `IDX_ADJ_SEL) idx_max = `MAX_ADJ_SEL;
        if (idx == `IDX_IO_MODE) idx_max = `MAX_IO_MODE;
        if (idx == `IDX_DI_FORCE) idx_max = `MAX_DI_FORCE;
        if (idx == `IDX_DO_FORCE) idx_max = `MAX_DO_FORCE;
        if (idx == `IDX_ENC_CMD) idx_max = `MAX_ENC_CMD;
    endfunction : idx_max

    // ****************************************************************
    // Setting registers
    // ****************************************************************
    logic        sw_reg;
    logic        fr_reg;
    logic        es_reg;
    logic [1:0]  adj_reg;
    logic [1:0]  iom_reg;
    logic [8:0]  dif_reg;
    logic [4:0]  dof_reg;
    logic [1:0]  enc_reg;
    logic        grav_reg;
    logic        soft_rst_reg;
    logic        adj_busy;
    logic        adj_done;
    logic [1:0]  adj_done_sel;
    logic [15:0] adj_offset;

    // Soft reset reloads the bank exactly as power-on does
    wire bank_rst = SRST_IN | soft_rst_reg;

    // ****************************************************************
    // Request qualification
    // ****************************************************************
    wire [7:0]  req_idx   = PARAM_REQ_IN.idx;
    wire [15:0] req_data  = PARAM_REQ_IN.wdata;
    wire        known     = idx_known(req_idx);
    wire        in_range  = (req_data <= idx_max(req_idx));
    wire        adj_hit   = (req_idx == `IDX_ADJ_SEL);
    // A new adjustment cannot start over one that is running
    wire        adj_clash = adj_hit & adj_busy & (req_data != 16'h0000);
    wire        wr_ok     = PARAM_REQ_IN.wr & known & in_range & ~adj_clash;
    wire        wr_bad    = PARAM_REQ_IN.wr & ~(known & in_range & ~adj_clash);
    wire        rd_take   = PARAM_REQ_IN.rd & ~PARAM_REQ_IN.wr;
    wire        bit0      = req_data[0];

    wire wr_sw    = wr_ok & (req_idx == `IDX_SW_RESET);
    wire wr_fr    = wr_ok & (req_idx == `IDX_FAULT_RESET);
    wire wr_es    = wr_ok & (req_idx == `IDX_ESTOP);
    wire wr_adj   = wr_ok & adj_hit;
    wire wr_iom   = wr_ok & (req_idx == `IDX_IO_MODE);
    wire wr_dif   = wr_ok & (req_idx == `IDX_DI_FORCE);
    wire wr_dof   = wr_ok & (req_idx == `IDX_DO_FORCE);
    wire wr_enc   = wr_ok & (req_idx == `IDX_ENC_CMD);
    wire wr_grav  = wr_ok & (req_idx == `IDX_GRAV);

    // ****************************************************************
    // Software reset
    // ****************************************************************
    wire sw_allowed = ~SERVO_ON_IN & ~NONRESET_FAULT_IN & ~NVM_BUSY_IN;
    wire sw_fire    = sw_reg & sw_allowed & ~RESET_INHIBIT_IN;
    // A pending request dies as soon as the inhibit is raised
    wire sw_next    = wr_sw ? (bit0 & ~RESET_INHIBIT_IN) :
                      (sw_reg & ~RESET_INHIBIT_IN & ~sw_fire);

    // ****************************************************************
    // Fault reset
    // ****************************************************************
    // Warnings clear on the write itself, whether running or not
    wire warn_clr  = wr_fr & bit0;
    // Only resettable classes are cleared, and only once stopped
    wire fault_clr = fr_reg & ~RUNNING_IN;
    wire fr_next   = wr_fr ? bit0 : (fr_reg & ~fault_clr);

    // ****************************************************************
    // Analog adjustment
    // ****************************************************************
    wire       adj_start = wr_adj & ((req_data[1:0] == `ADJ_AIN_ONE) ||
                                     (req_data[1:0] == `ADJ_AIN_TWO));
    wire [1:0] adj_next  = wr_adj ? req_data[1:0] :
                           (adj_done ? 2'h0 : adj_reg);

    // ****************************************************************
    // Encoder and gravity commands
    // ****************************************************************
    // Encoder command acts once and returns to no action
    wire [1:0] enc_next   = wr_enc ? req_data[1:0] : 2'h0;
    wire       grav_ok    = grav_reg & GRAV_DONE_IN & GRAV_OK_IN;
    // Fresh software write wins over the self-clear in the same cycle
    wire       grav_next  = wr_grav ? bit0 : (grav_reg & ~grav_ok);

    // ****************************************************************
    // Forcing mode decode
    // ****************************************************************
    wire di_forced = iom_reg[`IO_BIT_DI];
    wire do_forced = iom_reg[`IO_BIT_DO];

    // ****************************************************************
    // Read-back and answer
    // ****************************************************************
    wire [15:0] rd_mux =
        (req_idx == `IDX_SW_RESET)    ? {15'h0000, sw_reg}   :
        (req_idx == `IDX_FAULT_RESET) ? {15'h0000, fr_reg}   :
        (req_idx == `IDX_ESTOP)       ? {15'h0000, es_reg}   :
        (req_idx == `IDX_ADJ_SEL)     ? {14'h0000, adj_reg}  :
        (req_idx == `IDX_IO_MODE)     ? {14'h0000, iom_reg}  :
        (req_idx == `IDX_DI_FORCE)    ? {7'h00, dif_reg}     :
        (req_idx == `IDX_DO_FORCE)    ? {11'h000, dof_reg}   :
        (req_idx == `IDX_ENC_CMD)     ? {14'h0000, enc_reg}  :
        (req_idx == `IDX_GRAV)        ? {15'h0000, grav_reg} : 16'h0000;
    wire        rsp_err = wr_bad | (rd_take & ~known);
    wire [15:0] rsp_dat = (rd_take & known) ? rd_mux : 16'h0000;
    // Keypad writes may be saved; serial writes to this group never are
    wire        persist = wr_ok & ~PARAM_REQ_IN.from_comm;

    // ****************************************************************
    // Soft reset pulse, cleared only by power-on reset
    // ****************************************************************
    always_ff @(posedge CLK_SYS_IN) begin
        if (CE_IN) begin
            if (SRST_IN) begin
                soft_rst_reg   <= 1'b0;
                SOFT_RESET_OUT <= 1'b0;
            end else begin
                soft_rst_reg   <= sw_fire;
                SOFT_RESET_OUT <= sw_fire;
            end
        end
    end

    // ****************************************************************
    // Bank registers
    // ****************************************************************
    always_ff @(posedge CLK_SYS_IN) begin
        if (CE_IN) begin
            if (bank_rst) begin
                sw_reg   <= 1'b0;
                fr_reg   <= 1'b0;
                es_reg   <= 1'b0;
                adj_reg  <= 2'h0;
                iom_reg  <= 2'h0;
                dif_reg  <= `RST_DI_FORCE;
                dof_reg  <= 5'h00;
                enc_reg  <= 2'h0;
                grav_reg <= 1'b0;
            end else begin
                sw_reg   <= sw_next;
                fr_reg   <= fr_next;
                adj_reg  <= adj_next;
                enc_reg  <= enc_next;
                grav_reg <= grav_next;
                if (wr_es) es_reg <= bit0;
                if (wr_iom) iom_reg <= req_data[1:0];
                if (wr_dif) dif_reg <= req_data[8:0];
                if (wr_dof) dof_reg <= req_data[4:0];
            end
        end
    end

    // ****************************************************************
    // Action and answer outputs
    // ****************************************************************
    always_ff @(posedge CLK_SYS_IN) begin
        if (CE_IN) begin
            if (bank_rst) begin
                PARAM_RSP_OUT      <= '0;
                PERSIST_REQ_OUT    <= 1'b0;
                WARN_CLEAR_OUT     <= 1'b0;
                FAULT_CLEAR_OUT    <= 1'b0;
                ESTOP_OUT          <= 1'b0;
                ESTOP_MODE_OUT     <= 2'h0;
                ANA_OFFSET_WR_OUT  <= 1'b0;
                ANA_OFFSET_SEL_OUT <= 2'h0;
                ANA_OFFSET_OUT     <= 16'h0000;
                ENC_FAULT_CLR_OUT  <= 1'b0;
                ENC_TURNS_CLR_OUT  <= 1'b0;
                GRAV_START_OUT     <= 1'b0;
                GRAV_RESULT_WR_OUT <= 1'b0;
                GRAV_RESULT_OUT    <= 16'h0000;
            end else begin
                PARAM_RSP_OUT.ack   <= PARAM_REQ_IN.wr | PARAM_REQ_IN.rd;
                PARAM_RSP_OUT.err   <= rsp_err;
                PARAM_RSP_OUT.rdata <= rsp_dat;
                PERSIST_REQ_OUT     <= persist;
                WARN_CLEAR_OUT      <= warn_clr;
                FAULT_CLEAR_OUT     <= fault_clr;
                ESTOP_OUT           <= es_reg;
                ESTOP_MODE_OUT      <= STOP_MODE_IN;
                ANA_OFFSET_WR_OUT   <= adj_done;
                ENC_FAULT_CLR_OUT   <= (enc_reg != 2'h0);
                ENC_TURNS_CLR_OUT   <= (enc_reg == `ENC_CLR_TURNS);
                GRAV_START_OUT      <= wr_grav & bit0;
                GRAV_RESULT_WR_OUT  <= grav_ok;
                if (adj_done) begin
                    ANA_OFFSET_SEL_OUT <= adj_done_sel;
                    ANA_OFFSET_OUT     <= adj_offset;
                end
                if (grav_ok) GRAV_RESULT_OUT <= GRAV_RESULT_IN;
            end
        end
    end

    // ****************************************************************
    // Sub-blocks
    // ****************************************************************
    drift_adjust u_drift (
        .clk_in          (CLK_SYS_IN),
        .rst_in          (bank_rst),
        .ce_in           (CE_IN),
        .start_in        (adj_start),
        .sel_in          (req_data[1:0]),
        .ain1_in         (AIN1_IN),
        .ain2_in         (AIN2_IN),
        .sample_valid_in (AIN_VALID_IN),
        .busy_out        (adj_busy),
        .done_out        (adj_done),
        .done_sel_out    (adj_done_sel),
        .offset_out      (adj_offset)
    );

    io_force_unit u_io (
        .clk_in         (CLK_SYS_IN),
        .rst_in         (bank_rst),
        .ce_in          (CE_IN),
        .di_pin_in      (DI_PIN_IN),
        .di_force_in    (di_forced),
        .di_levels_in   (dif_reg),
        .do_force_in    (do_forced),
        .do_states_in   (dof_reg),
        .do_func_in     (DO_FUNC_IN),
        .do_polarity_in (DO_POLARITY_IN),
        .di_level_out   (DI_LEVEL_OUT),
        .do_pin_out     (DO_PIN_OUT)
    );

endmodule : aux_function_control

// ===== tb/aux_function_control_props.sv
`timescale 1ns/1ns
module aux_props (
    input wire logic CLK_SYS_IN, SRST_IN, CE_IN, SERVO_ON_IN, RUNNING_IN, NONRESET_FAULT_IN,
    input wire logic NVM_BUSY_IN, RESET_INHIBIT_IN, PERSIST_REQ_OUT, SOFT_RESET_OUT,
    input wire logic WARN_CLEAR_OUT, FAULT_CLEAR_OUT, ENC_FAULT_CLR_OUT, ENC_TURNS_CLR_OUT,
    input wire logic GRAV_START_OUT,
    input wire logic [1:0] STOP_MODE_IN, ESTOP_MODE_OUT,
    input wire aux_pkg::param_req_t PARAM_REQ_IN
);
    // ****
    // Checks
    // ****
    default clocking @(posedge CLK_SYS_IN); endclocking
    default disable iff (SRST_IN);
    wire logic        wr  = CE_IN && PARAM_REQ_IN.wr;
    wire logic [23:0] cmd = {PARAM_REQ_IN.idx, PARAM_REQ_IN.wdata};
    serial_no_save_a: assert property (wr && PARAM_REQ_IN.from_comm |=> !PERSIST_REQ_OUT)
        else $error("save request after serial write");
    inhibit_blocks_a: assert property (SOFT_RESET_OUT |-> $past(!RESET_INHIBIT_IN))
        else $error("soft reset while inhibited");
    reset_cond_a: assert property (SOFT_RESET_OUT |-> $past(!SERVO_ON_IN && !NVM_BUSY_IN
        && !NONRESET_FAULT_IN)) else $error("soft reset while not allowed");
    warn_clear_a: assert property (wr && cmd == 24'h01_0001 |=> WARN_CLEAR_OUT)
        else $error("no warning clear");
    fault_stop_a: assert property (FAULT_CLEAR_OUT |-> $past(!RUNNING_IN))
        else $error("fault clear while running");
    estop_mode_a: assert property ($past(CE_IN && !SRST_IN) && !$past(SOFT_RESET_OUT)
        && !$past(SOFT_RESET_OUT, 2) |-> ESTOP_MODE_OUT == $past(STOP_MODE_IN))
        else $error("stop mode not followed");
    enc_both_a: assert property (wr && cmd == 24'h14_0002 |=> ##1 ENC_FAULT_CLR_OUT
        && ENC_TURNS_CLR_OUT) else $error("encoder clear missing");
    grav_start_a: assert property (wr && cmd == 24'h18_0001 |=> GRAV_START_OUT)
        else $error("gravity tuning not started");
    cover property (SOFT_RESET_OUT);
    cover property (FAULT_CLEAR_OUT);
    cover property (ENC_TURNS_CLR_OUT);
endmodule : aux_props
bind aux_function_control aux_props u_props (.*);

// ===== tb/host_model.sv
`timescale 1ns/1ns
module host_model (
    input  wire logic                clk_in,
    input  wire logic                go_in,
    input  wire aux_pkg::param_req_t cmd_in,
    input  wire aux_pkg::param_rsp_t rsp_in,
    output aux_pkg::param_req_t      req_out,
    output aux_pkg::param_rsp_t      last_out
);
    initial req_out = '0;
    // Idle bus shows inverted leftovers, never the last word; origin flag cleared
    always @(posedge clk_in) begin
        req_out <= go_in ? cmd_in : {3'h0, ~cmd_in.idx, ~cmd_in.wdata};
        if (rsp_in.ack) last_out <= rsp_in;
    end
endmodule : host_model

// ===== tb/aux_function_control_tb.sv
`timescale 1ns/1ns
module aux_function_control_tb;
    logic CLK_SYS_IN = 0, SRST_IN = 1, CE_IN = 1, SERVO_ON_IN = 0, RUNNING_IN = 0, go = 0;
    logic NONRESET_FAULT_IN = 0, NVM_BUSY_IN = 0, RESET_INHIBIT_IN = 0, AIN_VALID_IN = 0;
    logic GRAV_DONE_IN = 0, GRAV_OK_IN = 0;
    logic [1:0] STOP_MODE_IN = 2'h2, ESTOP_MODE_OUT, ANA_OFFSET_SEL_OUT;
    logic [15:0] AIN1_IN = 16'h0000, AIN2_IN = 16'h0000, GRAV_RESULT_IN = 16'h0000;
    logic [15:0] ANA_OFFSET_OUT, GRAV_RESULT_OUT;
    logic [8:0] DI_PIN_IN = 9'h055, DI_LEVEL_OUT;
    logic [4:0] DO_FUNC_IN = 5'h03, DO_POLARITY_IN = 5'h00, DO_PIN_OUT;
    aux_pkg::param_req_t PARAM_REQ_IN, cmd = '0;
    aux_pkg::param_rsp_t PARAM_RSP_OUT, last;
    logic PERSIST_REQ_OUT, SOFT_RESET_OUT, WARN_CLEAR_OUT, FAULT_CLEAR_OUT, ESTOP_OUT;
    logic ANA_OFFSET_WR_OUT, ENC_FAULT_CLR_OUT, ENC_TURNS_CLR_OUT, GRAV_START_OUT;
    logic GRAV_RESULT_WR_OUT;
    int n_fail = 0, num_checks = 0, cyc = 0;
    // Rows: refusal flag, index, value
    logic [24:0] rows [14] = '{25'h1_00_0002, 25'h1_03_0000, 25'h1_0A_0003, 25'h1_11_0004,
        25'h1_12_0200, 25'h1_13_0020, 25'h1_14_0003, 25'h0_05_0001, 25'h0_11_0003,
        25'h0_12_00AA, 25'h0_13_001E, 25'h0_01_0001, 25'h0_14_0002, 25'h0_18_0001};
    aux_function_control uut (.*);
    host_model host (.clk_in(CLK_SYS_IN), .go_in(go), .cmd_in(cmd), .rsp_in(PARAM_RSP_OUT),
                     .req_out(PARAM_REQ_IN), .last_out(last));
    always #2 CLK_SYS_IN = ~CLK_SYS_IN;
    task stop_test;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : stop_test
    task chk(input logic [15:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // Answer lands one edge after the host strobe; read it once settled
    task acc(input logic wr, input logic [7:0] idx, input logic [15:0] d);
        @(posedge CLK_SYS_IN);
        cmd <= '{wr, !wr, 1'b1, idx, d};
        go <= 1'b1;
        @(posedge CLK_SYS_IN);
        go <= 1'b0;
        repeat (2) @(posedge CLK_SYS_IN);
        #1;
    endtask : acc
    always @(posedge CLK_SYS_IN) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            stop_test;
        end
    end
    initial begin
        repeat (10) @(posedge CLK_SYS_IN);
        SRST_IN <= 1'b0;
        acc(1'b0, 8'h00, 16'h0000);
        chk(last.rdata, 16'h0000);
        acc(1'b0, 8'h12, 16'h0000);
        chk(last.rdata, 16'h01FF);
        chk(16'(DI_LEVEL_OUT), 16'h0055);
        chk(16'(DO_PIN_OUT), 16'h001C);
        for (int i = 0; i < 14; i++) begin
            acc(1'b1, rows[i][23:16], rows[i][15:0]);
            chk(16'(last.err), 16'(rows[i][24]));
        end
        chk(16'(ESTOP_OUT), 16'h0001);
        chk(16'(DI_LEVEL_OUT), 16'h00AA);
        chk(16'(DO_PIN_OUT), 16'h0001);
        $display("table done");
        @(posedge CLK_SYS_IN);
        {GRAV_DONE_IN, GRAV_OK_IN, GRAV_RESULT_IN} <= {2'h3, 16'h1234};
        @(posedge CLK_SYS_IN);
        {GRAV_DONE_IN, GRAV_OK_IN} <= 2'h0;
        acc(1'b0, 8'h18, 16'h0000);
        chk(last.rdata, 16'h0000);
        chk(GRAV_RESULT_OUT, 16'h1234);
        $display("gravity done");
        @(posedge CLK_SYS_IN);
        RESET_INHIBIT_IN <= 1'b1;
        acc(1'b1, 8'h00, 16'h0001);
        acc(1'b0, 8'h00, 16'h0000);
        chk(last.rdata, 16'h0000);
        @(posedge CLK_SYS_IN);
        {RESET_INHIBIT_IN, SERVO_ON_IN} <= 2'h1;
        acc(1'b1, 8'h00, 16'h0001);
        acc(1'b0, 8'h00, 16'h0000);
        chk(last.rdata, 16'h0001);
        @(posedge CLK_SYS_IN);
        SERVO_ON_IN <= 1'b0;
        for (int i = 0; i < 10 && SOFT_RESET_OUT !== 1'b1; i++) begin
            @(posedge CLK_SYS_IN);
            #1;
        end
        chk(16'(SOFT_RESET_OUT), 16'h0001);
        acc(1'b0, 8'h12, 16'h0000);
        chk(last.rdata, 16'h01FF);
        chk(16'(ESTOP_OUT), 16'h0000);
        $display("soft reset done");
        @(posedge CLK_SYS_IN);
        {AIN_VALID_IN, AIN1_IN} <= {1'b1, 16'h0010};
        acc(1'b1, 8'h0A, 16'h0001);
        for (int i = 0; i < 400 && ANA_OFFSET_WR_OUT !== 1'b1; i++) begin
            @(posedge CLK_SYS_IN);
            #1;
        end
        chk(ANA_OFFSET_OUT, 16'hFFF0);
        chk(16'(ANA_OFFSET_SEL_OUT), 16'h0001);
        $display("adjust done");
        stop_test;
    end
endmodule : aux_function_control_tb
